// ==== design/lpms_pkg.sv ====
// Package of constants and types for the low-power mode supervisor
package lpms_pkg;
  // Register offsets (word addresses on the plain register port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_MODE = 4'h1;
  localparam logic [3:0] REG_PULL = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_WAKE_CFG = 4'h4;
  localparam logic [3:0] REG_DET_FLAGS = 4'h5;
  // Control register fields
  localparam int CTRL_CONV_ON = 0;
  localparam int CTRL_AUTO_BYPASS = 1;
  localparam int CTRL_DET_EN = 2;
  localparam int CTRL_DET_FALL = 3;
  localparam int CTRL_DET_RISE = 4;
  localparam int CTRL_RETAIN = 5;
  localparam int CTRL_RTC_KEEP = 6;
  localparam int CTRL_CLK_MULTI = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Wakeup configuration fields
  localparam int WCFG_PIN_EN = 0;
  localparam int WCFG_PIN_RISE = 1;
  localparam logic [1:0] WCFG_RESET = 2'h0;
  // Mode request codes written by software
  localparam logic [2:0] REQ_RUN = 3'h0;
  localparam logic [2:0] REQ_SLEEP = 3'h1;
  localparam logic [2:0] REQ_LP_RUN = 3'h2;
  localparam logic [2:0] REQ_LP_SLEEP = 3'h3;
  localparam logic [2:0] REQ_STOP0 = 3'h4;
  localparam logic [2:0] REQ_STOP1 = 3'h5;
  localparam logic [2:0] REQ_STANDBY = 3'h6;
  // System clock selection after wakeup
  localparam logic [1:0] CLK_INT16 = 2'h0;
  localparam logic [1:0] CLK_MULTI = 2'h1;
  localparam int PINS = 16;

  typedef enum logic [6:0] {
    ST_RUN      = 7'h01,
    ST_SLEEP    = 7'h02,
    ST_LP_RUN   = 7'h04,
    ST_LP_SLEEP = 7'h08,
    ST_STOP0    = 7'h10,
    ST_STOP1    = 7'h20,
    ST_STANDBY  = 7'h40
  } lpms_state_type;

  // Power level used to merge the two parties' needs; higher keeps more powered
  function automatic logic [2:0] level_of(input logic [2:0] req);
    unique case (req)
      REQ_RUN, REQ_SLEEP: level_of = 3'h6;
      REQ_LP_RUN: level_of = 3'h5;
      REQ_LP_SLEEP: level_of = 3'h4;
      REQ_STOP0: level_of = 3'h3;
      REQ_STOP1: level_of = 3'h2;
      default: level_of = 3'h1;
    endcase
  endfunction
endpackage

// ==== design/lpms_det_if.sv ====
// Interface carrying the supply detector configuration and event
`timescale 1ns/1ps
`default_nettype none
interface lpms_det_if;
  logic enable;
  logic on_fall;
  logic on_rise;
  logic event_p;
  modport ctl (output enable, output on_fall, output on_rise, input event_p);
  modport det (input enable, input on_fall, input on_rise, output event_p);
endinterface
`default_nettype wire

// ==== design/lpms_supply_detector.sv ====
// Supply voltage detector edge logic producing interrupt events
`timescale 1ns/1ps
`default_nettype none
module lpms_supply_detector (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Comparator level: high while supply is below threshold
  input wire logic below_i,
  // Configuration and event
  lpms_det_if.det det
);
  typedef struct packed {
    logic below;
    logic ev;
  } lpms_det_state_type;
  lpms_det_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.below = below_i;
    s_d.ev = det.enable &&
             ((det.on_fall && below_i && !s_q.below) ||
              (det.on_rise && !below_i && s_q.below));
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign det.event_p = s_q.ev;
endmodule
`default_nettype wire

// ==== design/lpms_supervisor.sv ====
// Low-power mode supervisor: regulators, converter bypass, modes and wakeup
// Notes on behaviour
// - Auto mode bypasses converter below brown-out level outside Stop 1 and Standby
// - Converter starts bypassed after reset
// - Software may enable or bypass converter anytime
// - Control bit selects auto bypass; level from options
// - Main regulator feeds Run, Sleep, Stop 0
// - Low-power regulator: LP modes, Stop1, retention
// - Standby turns off main regulator; LP regulator only if retaining
// - Reset leaves Run; low-power only by software
// - Sleep halts only processor; events wake it
// - LP sleep only from LP run, back there
// - Stop keeps contents and low-speed oscillator
// - Stop 0 keeps main regulator on
// - Brown-out reset stays active in Standby
// - Standby pins take software-chosen pull state
// - Standby loses registers; memories optionally retained
// - Listed sources wake device from Standby
// - Standby wakeup clock 16 MHz; blocked by radio
// - Brown-out holds reset while supply low
// - Supply detector interrupt on configured crossings
// - Analog monitor reports supply within range
// - Effective state is higher of both needs
`timescale 1ns/1ps
`default_nettype none
module lpms_supervisor #(
  parameter int PINS = lpms_pkg::PINS
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Supply comparators
  input wire logic vdd_below_bor_i,
  input wire logic vdd_below_det_i,
  input wire logic vdda_ok_i,
  // Radio subsystem
  input wire logic radio_active_i,
  input wire logic [2:0] radio_req_i,
  // Wakeup sources
  input wire logic irq_event_i,
  input wire logic ext_reset_pin_i,
  input wire logic watchdog_reset_i,
  input wire logic wakeup_pin_i,
  input wire logic rtc_event_i,
  input wire logic osc_fail_i,
  // Power control outputs
  output logic brownout_reset_o,
  output logic converter_bypass_o,
  output logic main_reg_on_o,
  output logic lp_reg_on_o,
  output logic core_reg_hiz_o,
  output logic core_domain_on_o,
  output logic mem_retain_o,
  output logic regs_retain_o,
  output logic lowspeed_osc_on_o,
  output logic rtc_on_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic [1:0] sysclk_sel_o,
  output logic standby_o,
  output logic [PINS-1:0] pin_pull_up_o,
  output logic [PINS-1:0] pin_pull_down_o,
  output logic supply_irq_o,
  output logic [6:0] mode_o
);
  typedef struct packed {
    lpms_pkg::lpms_state_type st;
    logic [7:0] ctrl;
    logic [1:0] wcfg;
    logic [2:0] req;
    logic [2*PINS-1:0] pull;
    logic conv_on;
    logic bor;
    logic wpin;
    logic det_flag;
    logic [1:0] clk;
    logic [31:0] rdata;
  } lpms_top_state_type;
  lpms_top_state_type s_q, s_d;

  lpms_det_if det_bus ();
  assign det_bus.enable = s_q.ctrl[lpms_pkg::CTRL_DET_EN];
  assign det_bus.on_fall = s_q.ctrl[lpms_pkg::CTRL_DET_FALL];
  assign det_bus.on_rise = s_q.ctrl[lpms_pkg::CTRL_DET_RISE];

  lpms_supply_detector u_det (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .below_i(vdd_below_det_i),
    .det(det_bus)
  );

  logic wake_any;
  logic pin_edge;
  logic standby_wake;
  logic [2:0] eff_req;

  always_comb begin
    pin_edge = s_q.wcfg[lpms_pkg::WCFG_PIN_EN] &&
      (s_q.wcfg[lpms_pkg::WCFG_PIN_RISE] ? (wakeup_pin_i && !s_q.wpin)
                                         : (!wakeup_pin_i && s_q.wpin));
    standby_wake = ext_reset_pin_i || watchdog_reset_i || pin_edge ||
                   rtc_event_i || osc_fail_i;
    wake_any = irq_event_i || standby_wake;
    // Radio request only counts while radio is active
    eff_req = s_q.req;
    if (radio_active_i &&
        lpms_pkg::level_of(radio_req_i) > lpms_pkg::level_of(s_q.req)) begin
      eff_req = radio_req_i;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.wpin = wakeup_pin_i;
    s_d.bor = vdd_below_bor_i;
    if (det_bus.event_p) begin
      s_d.det_flag = 1'b1;
    end
    // Register writes
    if (wr_i) begin
      unique case (addr_i)
        lpms_pkg::REG_CTRL: begin
          s_d.ctrl = wdata_i[7:0];
          s_d.conv_on = wdata_i[lpms_pkg::CTRL_CONV_ON];
        end
        lpms_pkg::REG_MODE: s_d.req = wdata_i[2:0];
        lpms_pkg::REG_PULL: s_d.pull = wdata_i[2*PINS-1:0];
        lpms_pkg::REG_WAKE_CFG: s_d.wcfg = wdata_i[1:0];
        lpms_pkg::REG_DET_FLAGS: begin
          if (wdata_i[0] && !det_bus.event_p) begin
            s_d.det_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Mode sequencer
    unique case (s_q.st)
      lpms_pkg::ST_RUN: begin
        unique case (eff_req)
          lpms_pkg::REQ_SLEEP: s_d.st = lpms_pkg::ST_SLEEP;
          lpms_pkg::REQ_LP_RUN: begin
            if (!radio_active_i) begin
              s_d.st = lpms_pkg::ST_LP_RUN;
            end
          end
          lpms_pkg::REQ_STOP0: begin
            if (!wake_any) begin
              s_d.st = lpms_pkg::ST_STOP0;
            end
          end
          lpms_pkg::REQ_STOP1: begin
            if (!wake_any) begin
              s_d.st = lpms_pkg::ST_STOP1;
            end
          end
          lpms_pkg::REQ_STANDBY: begin
            if (!wake_any && !radio_active_i) begin
              s_d.st = lpms_pkg::ST_STANDBY;
            end
          end
          default: ;
        endcase
      end
      lpms_pkg::ST_SLEEP: begin
        if (wake_any) begin
          s_d.st = lpms_pkg::ST_RUN;
          s_d.req = lpms_pkg::REQ_RUN;
        end
      end
      lpms_pkg::ST_LP_RUN: begin
        if (eff_req == lpms_pkg::REQ_RUN) begin
          s_d.st = lpms_pkg::ST_RUN;
        end else if (eff_req == lpms_pkg::REQ_LP_SLEEP) begin
          s_d.st = lpms_pkg::ST_LP_SLEEP;
        end
      end
      lpms_pkg::ST_LP_SLEEP: begin
        if (wake_any) begin
          s_d.st = lpms_pkg::ST_LP_RUN;
          s_d.req = lpms_pkg::REQ_LP_RUN;
        end
      end
      lpms_pkg::ST_STOP0, lpms_pkg::ST_STOP1: begin
        if (wake_any) begin
          s_d.st = lpms_pkg::ST_RUN;
          s_d.req = lpms_pkg::REQ_RUN;
          s_d.clk = (s_q.ctrl[lpms_pkg::CTRL_CLK_MULTI] && !radio_active_i) ?
                    lpms_pkg::CLK_MULTI : lpms_pkg::CLK_INT16;
        end
      end
      lpms_pkg::ST_STANDBY: begin
        if (standby_wake) begin
          // Exit behaves as a reset of everything outside standby circuitry
          s_d.st = lpms_pkg::ST_RUN;
          s_d.req = lpms_pkg::REQ_RUN;
          s_d.clk = lpms_pkg::CLK_INT16;
          s_d.ctrl = lpms_pkg::CTRL_RESET;
          s_d.conv_on = 1'b0;
          s_d.det_flag = 1'b0;
        end
      end
      default: s_d.st = lpms_pkg::ST_RUN;
    endcase
    // Read data
    s_d.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        lpms_pkg::REG_CTRL: s_d.rdata = {24'h000000, s_q.ctrl};
        lpms_pkg::REG_MODE: s_d.rdata = {29'h0, s_q.req};
        lpms_pkg::REG_PULL: s_d.rdata = 32'(s_q.pull);
        lpms_pkg::REG_STATUS: s_d.rdata = {20'h00000, s_q.clk, vdda_ok_i,
                                           converter_bypass_o, s_q.bor,
                                           s_q.st};
        lpms_pkg::REG_WAKE_CFG: s_d.rdata = {30'h0, s_q.wcfg};
        lpms_pkg::REG_DET_FLAGS: s_d.rdata = {31'h0, s_q.det_flag};
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s_q <= '0;
      s_q.st <= lpms_pkg::ST_RUN;
      s_q.ctrl <= lpms_pkg::CTRL_RESET;
      s_q.wcfg <= lpms_pkg::WCFG_RESET;
      s_q.req <= lpms_pkg::REQ_RUN;
      s_q.conv_on <= 1'b0;
      s_q.clk <= lpms_pkg::CLK_INT16;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  logic in_standby;
  logic in_stop1;
  assign in_standby = s_q.st == lpms_pkg::ST_STANDBY;
  assign in_stop1 = s_q.st == lpms_pkg::ST_STOP1;

  // Brown-out bypass stays effective except in Stop 1 and Standby
  assign converter_bypass_o = !s_q.conv_on ||
    (s_q.ctrl[lpms_pkg::CTRL_AUTO_BYPASS] && s_q.bor && !in_stop1 &&
     !in_standby);
  assign brownout_reset_o = s_q.bor;
  assign main_reg_on_o = s_q.st inside {lpms_pkg::ST_RUN, lpms_pkg::ST_SLEEP,
                                        lpms_pkg::ST_STOP0};
  assign lp_reg_on_o = (s_q.st inside {lpms_pkg::ST_LP_RUN, lpms_pkg::ST_LP_SLEEP,
                                       lpms_pkg::ST_STOP1}) ||
                       (in_standby && s_q.ctrl[lpms_pkg::CTRL_RETAIN]);
  assign core_reg_hiz_o = in_standby;
  assign core_domain_on_o = !in_standby;
  assign mem_retain_o = !in_standby || s_q.ctrl[lpms_pkg::CTRL_RETAIN];
  assign regs_retain_o = !in_standby;
  assign lowspeed_osc_on_o = 1'b1;
  assign rtc_on_o = !(s_q.st inside {lpms_pkg::ST_STOP0, lpms_pkg::ST_STOP1,
                                     lpms_pkg::ST_STANDBY}) ||
                    s_q.ctrl[lpms_pkg::CTRL_RTC_KEEP];
  assign cpu_clk_en_o = s_q.st inside {lpms_pkg::ST_RUN, lpms_pkg::ST_LP_RUN};
  assign periph_clk_en_o = s_q.st inside {lpms_pkg::ST_RUN, lpms_pkg::ST_SLEEP,
                                          lpms_pkg::ST_LP_RUN,
                                          lpms_pkg::ST_LP_SLEEP};
  assign sysclk_sel_o = s_q.clk;
  assign standby_o = in_standby;
  assign pin_pull_up_o = in_standby ? s_q.pull[PINS-1:0] : '0;
  assign pin_pull_down_o = in_standby ?
    (s_q.pull[2*PINS-1:PINS] & ~s_q.pull[PINS-1:0]) : '0;
  assign supply_irq_o = s_q.det_flag;
  assign mode_o = s_q.st;
  assign rdata_o = s_q.rdata;
endmodule
`default_nettype wire

// ==== tb/lpms_partner.sv ====
// Model of the far side: wakeup sources and radio subsystem
`timescale 1ns/1ps
`default_nettype none
module lpms_partner (
  // Commands from the bench
  input wire logic clock_i,
  input wire logic [5:0] fire_i,
  input wire logic radio_on_i,
  input wire logic [6:0] mode_i,
  // Lines into the supervisor
  output logic [5:0] wake_o,
  output logic radio_active_o
);
  // Sources answer one cycle after being commanded
  always_ff @(posedge clock_i) begin
    wake_o <= fire_i;
    // Radio is kept off while the core runs or sleeps at low power
    radio_active_o <= radio_on_i & ~|mode_i[3:2];
  end
endmodule
`default_nettype wire

// ==== tb/lpms_assertions.sv ====
// Port checker for the low-power mode supervisor
`timescale 1ns/1ps
`default_nettype none
module lpms_assertions #(
  parameter int PINS = 16
) (
  // Inputs
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic rd_i,
  input wire logic vdd_below_bor_i,
  input wire logic irq_event_i,
  input wire logic ext_reset_pin_i,
  input wire logic watchdog_reset_i,
  input wire logic rtc_event_i,
  input wire logic osc_fail_i,
  // Outputs
  input wire logic [31:0] rdata_o,
  input wire logic brownout_reset_o,
  input wire logic converter_bypass_o,
  input wire logic main_reg_on_o,
  input wire logic lp_reg_on_o,
  input wire logic core_reg_hiz_o,
  input wire logic core_domain_on_o,
  input wire logic lowspeed_osc_on_o,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic [PINS-1:0] pin_pull_up_o,
  input wire logic [PINS-1:0] pin_pull_down_o,
  input wire logic [6:0] mode_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_bor_follow: assert property (
    $past(!srst_i) |-> brownout_reset_o == $past(vdd_below_bor_i)) else $error("bor lag");
  a_reset_run: assert property (
    $past(srst_i) |-> mode_o == 7'h01 && converter_bypass_o) else $error("reset state");
  a_main_reg: assert property (
    mode_o inside {7'h01, 7'h02, 7'h10} |-> main_reg_on_o) else $error("main reg off");
  a_lp_reg: assert property (
    mode_o inside {7'h04, 7'h08, 7'h20} |-> lp_reg_on_o) else $error("lp reg off");
  a_standby_off: assert property (
    mode_o == 7'h40 |-> core_reg_hiz_o && !core_domain_on_o && !main_reg_on_o)
    else $error("standby power");
  a_sleep_halt: assert property (
    mode_o inside {7'h02, 7'h08} |-> !cpu_clk_en_o && periph_clk_en_o) else $error("sleep clk");
  a_stop_keep: assert property (
    mode_o inside {7'h10, 7'h20} |-> lowspeed_osc_on_o && !core_reg_hiz_o)
    else $error("stop keep");
  a_pull_idle: assert property (
    mode_o != 7'h40 |-> pin_pull_up_o == '0 && pin_pull_down_o == '0) else $error("pulls");
  a_read_idle: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0) else $error("rdata idle");
  a_wake_blocks: assert property (
    mode_o == 7'h01 && (irq_event_i || ext_reset_pin_i || watchdog_reset_i || rtc_event_i ||
    osc_fail_i) |=> !(mode_o inside {7'h10, 7'h20, 7'h40})) else $error("entry with wake");
  c_standby: cover property (mode_o == 7'h40);
  c_lp_sleep: cover property (mode_o == 7'h08);
  c_stop1: cover property (mode_o == 7'h20);
endmodule
`default_nettype wire

// ==== tb/tb_lpms_supervisor.sv ====
// Self-checking testbench for the low-power mode supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_lpms_supervisor;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic bor = 1'b0;
  logic det = 1'b0;
  logic radio_on = 1'b0;
  logic ce = 1'b1;
  logic ok = 1'b1;
  logic mem_ret, reg_ret, rtc_on, sb;
  logic [2:0] radio_req = 3'h0;
  logic [5:0] fire = 6'h0;
  logic [5:0] wake;
  logic radio_act, bypass, bor_o, irq;
  logic [31:0] rdata_o;
  logic [1:0] clk_sel;
  logic [15:0] pu, pd;
  logic [6:0] mode_o;
  int fail_count = 0;
  int total_checks = 0;
  lpms_supervisor lpms_supervisor_inst (.clock_i, .srst_i, .ce_i(ce), .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .vdd_below_bor_i(bor), .vdd_below_det_i(det), .vdda_ok_i(ok),
    .radio_active_i(radio_act), .radio_req_i(radio_req), .irq_event_i(wake[5]),
    .ext_reset_pin_i(wake[4]), .watchdog_reset_i(wake[3]), .wakeup_pin_i(wake[2]),
    .rtc_event_i(wake[1]), .osc_fail_i(wake[0]), .brownout_reset_o(bor_o),
    .converter_bypass_o(bypass), .main_reg_on_o(), .lp_reg_on_o(), .core_reg_hiz_o(),
    .core_domain_on_o(), .mem_retain_o(mem_ret), .regs_retain_o(reg_ret), .lowspeed_osc_on_o(),
    .rtc_on_o(rtc_on), .cpu_clk_en_o(), .periph_clk_en_o(), .sysclk_sel_o(clk_sel),
    .standby_o(sb), .pin_pull_up_o(pu), .pin_pull_down_o(pd), .supply_irq_o(irq), .mode_o);
  lpms_partner lpms_partner_inst (.clock_i, .fire_i(fire), .radio_on_i(radio_on),
    .mode_i(mode_o), .wake_o(wake), .radio_active_o(radio_act));
  initial begin
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic close_out();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(negedge clock_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk(rdata_o, exp);
  endtask
  task automatic go(input logic [2:0] req);
    wr(lpms_pkg::REG_MODE, {29'h0, req});
  endtask
  // Mode must reach the expected state within a bounded wait
  task automatic want(input logic [6:0] exp);
    int n;
    n = 0;
    while (mode_o !== exp && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    chk(32'(mode_o), 32'(exp));
    if (n == 20) close_out();
  endtask
  task automatic stay(input logic [6:0] exp);
    repeat (3) @(negedge clock_i);
    chk(32'(mode_o), 32'(exp));
  endtask
  task automatic pulse(input int i);
    @(posedge clock_i);
    fire <= 6'(1 << i);
    @(posedge clock_i);
    fire <= 6'h0;
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    @(negedge clock_i);
    chk(32'(mode_o), 32'h01);
    chk(32'(bypass), 32'h1);
    rd(lpms_pkg::REG_STATUS, 32'h0301);
    wr(4'hF, 32'hFF);
    rd(4'hF, 32'h0);
    @(posedge clock_i);
    ok <= 1'b0;
    rd(lpms_pkg::REG_STATUS, 32'h0101);
    @(posedge clock_i);
    ok <= 1'b1;
    ce <= 1'b0;
    wr(lpms_pkg::REG_CTRL, 32'h01);
    @(posedge clock_i);
    ce <= 1'b1;
    rd(lpms_pkg::REG_CTRL, 32'h0);
    chk(32'(bypass), 32'h1);
    wr(lpms_pkg::REG_CTRL, 32'h01);
    chk(32'(bypass), 32'h0);
    wr(lpms_pkg::REG_CTRL, 32'h03);
    @(posedge clock_i);
    bor <= 1'b1;
    repeat (2) @(negedge clock_i);
    chk(32'(bor_o), 32'h1);
    chk(32'(bypass), 32'h1);
    wr(lpms_pkg::REG_CTRL, 32'h01);
    chk(32'(bypass), 32'h0);
    @(posedge clock_i);
    bor <= 1'b0;
    wr(lpms_pkg::REG_CTRL, 32'h00);
    chk(32'(bypass), 32'h1);
    go(lpms_pkg::REQ_SLEEP);
    want(7'h02);
    pulse(5);
    want(7'h01);
    go(lpms_pkg::REQ_LP_SLEEP);
    stay(7'h01);
    go(lpms_pkg::REQ_LP_RUN);
    want(7'h04);
    go(lpms_pkg::REQ_LP_SLEEP);
    want(7'h08);
    pulse(5);
    want(7'h04);
    go(lpms_pkg::REQ_RUN);
    want(7'h01);
    @(posedge clock_i);
    fire <= 6'h02;
    go(lpms_pkg::REQ_STOP0);
    stay(7'h01);
    @(posedge clock_i);
    fire <= 6'h00;
    wr(lpms_pkg::REG_CTRL, 32'h80);
    go(lpms_pkg::REQ_STOP0);
    want(7'h10);
    pulse(1);
    want(7'h01);
    chk(32'(clk_sel), 32'h1);
    @(posedge clock_i);
    radio_on <= 1'b1;
    go(lpms_pkg::REQ_STOP1);
    stay(7'h01);
    go(lpms_pkg::REQ_STANDBY);
    @(posedge clock_i);
    radio_req <= lpms_pkg::REQ_STANDBY;
    stay(7'h01);
    @(posedge clock_i);
    radio_req <= lpms_pkg::REQ_STOP1;
    want(7'h20);
    go(lpms_pkg::REQ_STOP1);
    want(7'h20);
    pulse(1);
    want(7'h01);
    chk(32'(clk_sel), 32'h0);
    @(posedge clock_i);
    radio_on <= 1'b0;
    wr(lpms_pkg::REG_WAKE_CFG, 32'h3);
    wr(lpms_pkg::REG_PULL, 32'h0003_0005);
    for (int i = 0; i < 5; i++) begin
      wr(lpms_pkg::REG_CTRL, (i % 2 == 1) ? 32'hE0 : 32'h80);
      go(lpms_pkg::REQ_STANDBY);
      want(7'h40);
      chk(32'(pu), 32'h5);
      chk(32'(pd), 32'h2);
      chk(32'({mem_ret, reg_ret, rtc_on, sb}), (i % 2 == 1) ? 32'hB : 32'h1);
      pulse(i);
      want(7'h01);
      chk(32'(clk_sel), 32'h0);
      rd(lpms_pkg::REG_CTRL, 32'h0);
    end
    wr(lpms_pkg::REG_CTRL, 32'h0C);
    @(posedge clock_i);
    det <= 1'b1;
    repeat (4) @(negedge clock_i);
    chk(32'(irq), 32'h1);
    rd(lpms_pkg::REG_DET_FLAGS, 32'h1);
    wr(lpms_pkg::REG_DET_FLAGS, 32'h1);
    @(posedge clock_i);
    det <= 1'b0;
    repeat (4) @(negedge clock_i);
    chk(32'(irq), 32'h0);
    close_out();
  end
endmodule
bind lpms_supervisor lpms_assertions #(.PINS(PINS)) lpms_assertions_inst (.clock_i, .srst_i,
  .rd_i, .vdd_below_bor_i, .irq_event_i, .ext_reset_pin_i, .watchdog_reset_i, .rtc_event_i,
  .osc_fail_i, .rdata_o, .brownout_reset_o, .converter_bypass_o, .main_reg_on_o,
  .lp_reg_on_o, .core_reg_hiz_o, .core_domain_on_o, .lowspeed_osc_on_o, .cpu_clk_en_o,
  .periph_clk_en_o, .pin_pull_up_o, .pin_pull_down_o, .mode_o);
`default_nettype wire
